// ### hw/pse_detect_resistance_readout.sv
// Detection resistance readout, detect/class restart control and serial command port
// Contract
// - Four read-only byte results at codes 44h..47h, ports one to four, reset zero.
// - Each result holds the latest two-point detection conversion, overwriting older.
// - Powering a port off leaves its stored result untouched.
// - Code N means N times a fixed resistance step; useful 2 to 50 kilohm.
// - After off command or disconnect, detection restarts only on a new host command.
// - Startup, overcurrent cut or current-limit fault starts cool-down; enables are postponed.
// - When cool-down ends, cycles restart automatically if enable bits are set.
`timescale 1ns/1ps
`default_nettype none
`include "pse_readout_consts.svh"
module pse_detect_resistance_readout
  import pse_readout_pkg::*;
#(
  parameter int PORTS = 4,
  parameter logic [6:0] DEV_ADDR = `SERIAL_DEV_ADDR,
  parameter int unsigned COOL_DOWN_CYCLES = `COOL_DOWN_CYCLES
)
(
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic nrst_i,
  // Serial command port, open drain
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  // Measurement engine
  input wire logic [PORTS-1:0] meas_done_i,
  input wire logic [PORTS*8-1:0] meas_code_i,
  input wire logic [PORTS-1:0] cycle_busy_i,
  output logic [PORTS-1:0] detect_start_o,
  output logic [PORTS-1:0] class_start_o,
  // Port power events
  input wire logic [PORTS-1:0] port_off_i,
  input wire logic [PORTS-1:0] startup_fault_i,
  input wire logic [PORTS-1:0] overcurrent_cut_fault_i,
  input wire logic [PORTS-1:0] current_limit_fault_i,
  output logic [PORTS-1:0] cooling_o
);
  if (PORTS != 4 || COOL_DOWN_CYCLES < 1)
  begin : bad_param
    $error("Unsupported PORTS or COOL_DOWN_CYCLES");
  end

  // Pin synchronisers; stage one feeds stage two only
  logic scl_m_reg, scl_s_reg, scl_d_reg, sda_m_reg, sda_s_reg, sda_d_reg;
  always_ff @(posedge core_clk_i)
  begin
    if (!nrst_i)
    begin
      scl_m_reg <= 1'b1;
      scl_s_reg <= 1'b1;
      scl_d_reg <= 1'b1;
      sda_m_reg <= 1'b1;
      sda_s_reg <= 1'b1;
      sda_d_reg <= 1'b1;
    end
    else
    begin
      scl_m_reg <= scl_i;
      scl_s_reg <= scl_m_reg;
      scl_d_reg <= scl_s_reg;
      sda_m_reg <= sda_i;
      sda_s_reg <= sda_m_reg;
      sda_d_reg <= sda_s_reg;
    end
  end

  logic scl_rise, scl_fall, bus_start, bus_stop;
  assign scl_rise = scl_s_reg & ~scl_d_reg;
  assign scl_fall = ~scl_s_reg & scl_d_reg;
  assign bus_start = scl_s_reg & scl_d_reg & sda_d_reg & ~sda_s_reg;
  assign bus_stop = scl_s_reg & scl_d_reg & ~sda_d_reg & sda_s_reg;

  // Serial state
  ser_state_type state_reg, state_next;
  logic [7:0] shift_reg, shift_next;
  logic [3:0] cnt_reg, cnt_next;
  logic [7:0] cmd_reg, cmd_next;
  logic rw_reg, rw_next;
  logic nack_reg, nack_next;
  logic oe_reg, oe_next;
  logic en_wr;
  logic [7:0] rd_byte;
  logic [7:0] store_rd;
  logic [PORTS-1:0] det_en_reg, det_en_next, cls_en_reg, cls_en_next;

  // Results, enable and cool-down status; unknown codes read zero
  always_comb
  begin
    rd_byte = 8'h00;
    if (cmd_reg >= `PORT1_DETECT_RESISTANCE && cmd_reg <= `PORT4_DETECT_RESISTANCE)
    begin
      rd_byte = store_rd;
    end
    else if (cmd_reg == `DETECT_CLASS_ENABLE)
    begin
      rd_byte = {cls_en_reg, det_en_reg};
    end
    else if (cmd_reg == `COOL_DOWN_STATUS)
    begin
      rd_byte = {4'h0, cooling_o};
    end
  end

  always_comb
  begin
    state_next = state_reg;
    shift_next = shift_reg;
    cnt_next = cnt_reg;
    cmd_next = cmd_reg;
    rw_next = rw_reg;
    nack_next = nack_reg;
    oe_next = oe_reg;
    en_wr = 1'b0;
    if (bus_stop)
    begin
      state_next = SER_IDLE;
      oe_next = 1'b0;
    end
    else if (bus_start)
    begin
      state_next = SER_ADDR;
      cnt_next = 4'h0;
      oe_next = 1'b0;
    end
    else
    begin
      unique case (state_reg)
        SER_IDLE:
        begin
          oe_next = 1'b0;
        end
        SER_ADDR, SER_CMD, SER_WDATA:
        begin
          if (scl_rise)
          begin
            shift_next = {shift_reg[6:0], sda_s_reg};
            cnt_next = cnt_reg + 4'h1;
          end
          else if (scl_fall && cnt_reg == 4'h8)
          begin
            cnt_next = 4'h0;
            oe_next = 1'b1;
            if (state_reg == SER_ADDR)
            begin
              rw_next = shift_reg[0];
              state_next = (shift_reg[7:1] == DEV_ADDR) ? SER_ADDR_ACK : SER_IDLE;
              oe_next = (shift_reg[7:1] == DEV_ADDR);
            end
            else if (state_reg == SER_CMD)
            begin
              cmd_next = shift_reg;
              state_next = SER_CMD_ACK;
            end
            else
            begin
              en_wr = (cmd_reg == `DETECT_CLASS_ENABLE);
              state_next = SER_WDATA_ACK;
            end
          end
        end
        SER_ADDR_ACK:
        begin
          if (scl_fall)
          begin
            if (rw_reg)
            begin
              shift_next = rd_byte;
              oe_next = ~rd_byte[7];
              state_next = SER_RDATA;
            end
            else
            begin
              oe_next = 1'b0;
              state_next = SER_CMD;
            end
          end
        end
        SER_CMD_ACK, SER_WDATA_ACK:
        begin
          if (scl_fall)
          begin
            oe_next = 1'b0;
            state_next = SER_WDATA;
          end
        end
        SER_RDATA:
        begin
          if (scl_fall)
          begin
            if (cnt_reg == 4'h7)
            begin
              oe_next = 1'b0;
              state_next = SER_RDATA_ACK;
            end
            else
            begin
              shift_next = {shift_reg[6:0], 1'b0};
              oe_next = ~shift_reg[6];
              cnt_next = cnt_reg + 4'h1;
            end
          end
        end
        SER_RDATA_ACK:
        begin
          if (scl_rise)
          begin
            nack_next = sda_s_reg;
          end
          else if (scl_fall)
          begin
            // Repeated reads return the same register again
            cnt_next = 4'h0;
            shift_next = rd_byte;
            oe_next = ~nack_reg & ~rd_byte[7];
            state_next = nack_reg ? SER_IDLE : SER_RDATA;
          end
        end
        default:
        begin
          state_next = SER_IDLE;
          oe_next = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk_i)
  begin
    if (!nrst_i)
    begin
      state_reg <= SER_IDLE;
      shift_reg <= 8'h00;
      cnt_reg <= 4'h0;
      cmd_reg <= 8'h00;
      rw_reg <= 1'b0;
      nack_reg <= 1'b0;
      oe_reg <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      shift_reg <= shift_next;
      cnt_reg <= cnt_next;
      cmd_reg <= cmd_next;
      rw_reg <= rw_next;
      nack_reg <= nack_next;
      oe_reg <= oe_next;
    end
  end

  // Open drain: only ever pulls low
  logic sda_out_reg;
  always_ff @(posedge core_clk_i)
  begin
    sda_out_reg <= 1'b0;
  end
  assign sda_o = sda_out_reg;
  assign sda_oe_o = oe_reg;

  // Per-port enable, cool-down and cycle launch
  logic [PORTS-1:0] det_start_reg, det_start_next, cls_start_reg, cls_start_next;
  logic [31:0] cool_reg [PORTS];
  logic [31:0] cool_next [PORTS];
  for (genvar p = 0; p < PORTS; p++)
  begin : port_ctl
    logic fault;
    logic cooling;
    assign fault = startup_fault_i[p] | overcurrent_cut_fault_i[p] | current_limit_fault_i[p];
    assign cooling = (cool_reg[p] != 32'h0) | fault;

    always_comb
    begin
      // Host write wins over a same-cycle power-off
      if (en_wr)
      begin
        det_en_next[p] = shift_reg[`DET_EN_LSB + p];
        cls_en_next[p] = shift_reg[`CLS_EN_LSB + p];
      end
      else if (port_off_i[p])
      begin
        det_en_next[p] = 1'b0;
        cls_en_next[p] = 1'b0;
      end
      else
      begin
        det_en_next[p] = det_en_reg[p];
        cls_en_next[p] = cls_en_reg[p];
      end
      if (fault)
      begin
        cool_next[p] = COOL_DOWN_CYCLES;
      end
      else if (cool_reg[p] != 32'h0)
      begin
        cool_next[p] = cool_reg[p] - 32'h1;
      end
      else
      begin
        cool_next[p] = 32'h0;
      end
      // Enables stay armed through cool-down, so launch resumes by itself
      det_start_next[p] = (det_en_reg[p] | cls_en_reg[p]) & ~cooling & ~cycle_busy_i[p]
        & ~det_start_reg[p] & ~port_off_i[p];
      cls_start_next[p] = det_start_next[p] & cls_en_reg[p];
    end

    always_ff @(posedge core_clk_i)
    begin
      if (!nrst_i)
      begin
        cool_reg[p] <= 32'h0;
      end
      else
      begin
        cool_reg[p] <= cool_next[p];
      end
    end
  end

  logic [PORTS-1:0] cooling_reg;
  always_ff @(posedge core_clk_i)
  begin
    if (!nrst_i)
    begin
      det_en_reg <= '0;
      cls_en_reg <= '0;
      det_start_reg <= '0;
      cls_start_reg <= '0;
      cooling_reg <= '0;
    end
    else
    begin
      det_en_reg <= det_en_next;
      cls_en_reg <= cls_en_next;
      det_start_reg <= det_start_next;
      cls_start_reg <= cls_start_next;
      for (int p = 0; p < PORTS; p++)
      begin
        cooling_reg[p] <= (cool_next[p] != 32'h0);
      end
    end
  end
  assign detect_start_o = det_start_reg;
  assign class_start_o = cls_start_reg;
  assign cooling_o = cooling_reg;

  // Port power-off does not reach the store
  result_store #(.PORTS(PORTS), .WIDTH(8)) store_u
  (
    .core_clk_i(core_clk_i),
    .nrst_i(nrst_i),
    .wr_en_i(meas_done_i),
    .wr_data_i(meas_code_i),
    .rd_addr_i(cmd_reg[1:0]),
    .rd_data_o(store_rd)
  );
endmodule
`default_nettype wire

// ### hw/pse_readout_consts.svh
// Command codes, field positions, reset values and timing counts for the readout block
`ifndef PSE_READOUT_CONSTS_SVH
`define PSE_READOUT_CONSTS_SVH
`define PORT1_DETECT_RESISTANCE 8'h44
`define PORT2_DETECT_RESISTANCE 8'h45
`define PORT3_DETECT_RESISTANCE 8'h46
`define PORT4_DETECT_RESISTANCE 8'h47
`define DETECT_CLASS_ENABLE 8'h60
`define COOL_DOWN_STATUS 8'h61
`define RESULT_RESET 8'h00
`define DET_EN_LSB 0
`define CLS_EN_LSB 4
`define SERIAL_DEV_ADDR 7'h20
`define CLK_HZ 40000000
`define COOL_DOWN_MS 1000
`define COOL_DOWN_CYCLES ((`CLK_HZ / 1000) * `COOL_DOWN_MS)
`endif

// ### hw/pse_readout_pkg.sv
// Types shared by the readout block
package pse_readout_pkg;
  typedef enum logic [3:0]
  {
    SER_IDLE = 4'b0000,
    SER_ADDR = 4'b0001,
    SER_ADDR_ACK = 4'b0010,
    SER_CMD = 4'b0011,
    SER_CMD_ACK = 4'b0100,
    SER_WDATA = 4'b0101,
    SER_WDATA_ACK = 4'b0110,
    SER_RDATA = 4'b0111,
    SER_RDATA_ACK = 4'b1000
  } ser_state_type;
endpackage

// ### hw/result_store.sv
// Small per-port result memory with registered read data
`timescale 1ns/1ps
`default_nettype none
`include "pse_readout_consts.svh"
module result_store
#(
  parameter int PORTS = 4,
  parameter int WIDTH = 8
)
(
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic nrst_i,
  // Write side
  input wire logic [PORTS-1:0] wr_en_i,
  input wire logic [PORTS*WIDTH-1:0] wr_data_i,
  // Read side
  input wire logic [$clog2(PORTS)-1:0] rd_addr_i,
  output logic [WIDTH-1:0] rd_data_o
);
  logic [WIDTH-1:0] mem_reg [PORTS];
  logic [WIDTH-1:0] mem_next [PORTS];
  logic [WIDTH-1:0] rd_data_reg;
  logic [WIDTH-1:0] rd_data_next;

  // Whole word lands in one edge, so a read never sees half a code
  always_comb
  begin
    for (int p = 0; p < PORTS; p++)
    begin
      mem_next[p] = wr_en_i[p] ? wr_data_i[p*WIDTH +: WIDTH] : mem_reg[p];
    end
    rd_data_next = mem_reg[rd_addr_i];
  end

  always_ff @(posedge core_clk_i)
  begin
    if (!nrst_i)
    begin
      for (int p = 0; p < PORTS; p++)
      begin
        mem_reg[p] <= WIDTH'(`RESULT_RESET);
      end
      rd_data_reg <= '0;
    end
    else
    begin
      mem_reg <= mem_next;
      rd_data_reg <= rd_data_next;
    end
  end

  assign rd_data_o = rd_data_reg;
endmodule
`default_nettype wire

// ### tb/readout_assertions.sv
// Port-level assertions for the detection resistance readout block
`timescale 1ns/1ps
`default_nettype none
module readout_checker
#(
  parameter int PORTS = 4,
  parameter int unsigned COOL_DOWN_CYCLES = 20
)
(
  // Watched ports
  input wire logic core_clk_i,
  input wire logic nrst_i,
  input wire logic sda_o,
  input wire logic sda_oe_o,
  input wire logic [PORTS-1:0] cycle_busy_i,
  input wire logic [PORTS-1:0] detect_start_o,
  input wire logic [PORTS-1:0] class_start_o,
  input wire logic [PORTS-1:0] startup_fault_i,
  input wire logic [PORTS-1:0] overcurrent_cut_fault_i,
  input wire logic [PORTS-1:0] current_limit_fault_i,
  input wire logic [PORTS-1:0] cooling_o
);
  logic [PORTS-1:0] flt;
  logic [31:0] cool_cnt_reg;
  logic [31:0] cool_cnt_next;
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!nrst_i);
  assign flt = startup_fault_i | overcurrent_cut_fault_i | current_limit_fault_i;
  // Only port one is timed; the others share the same counter logic
  always_comb cool_cnt_next = cooling_o[0] ? cool_cnt_reg + 32'h1 : 32'h0;
  always_ff @(posedge core_clk_i) cool_cnt_reg <= nrst_i ? cool_cnt_next : 32'h0;
  fault_cools_a: assert property (|flt |=> (cooling_o & $past(flt)) == $past(flt))
    else $error("cool-down missing after fault");
  cool_no_start_a: assert property (!(|(detect_start_o & cooling_o)))
    else $error("start during cool-down");
  cool_length_a: assert property ($fell(cooling_o[0]) |-> cool_cnt_reg == COOL_DOWN_CYCLES)
    else $error("cool-down length wrong");
  start_gap_a: assert property (!(|(detect_start_o & $past(detect_start_o))))
    else $error("adjacent start pulses");
  class_with_det_a: assert property (!(|(class_start_o & ~detect_start_o)))
    else $error("class start without detect start");
  busy_blocks_a: assert property (!(|(detect_start_o & $past(cycle_busy_i))))
    else $error("start while engine busy");
  sda_low_only_a: assert property (!sda_o)
    else $error("data pin driven high");
  reset_idle_a: assert property ($rose(nrst_i) |-> !sda_oe_o && !(|cooling_o))
    else $error("outputs not idle after reset");
endmodule
`default_nettype wire

// ### tb/serial_host.sv
// Serial bus host model that reads and writes command codes
`timescale 1ns/1ps
`default_nettype none
module serial_host
#(
  parameter logic [6:0] DEV_ADDR = 7'h20
)
(
  // Clock and wire
  input wire logic core_clk_i,
  input wire logic dev_pull_i,
  output logic scl_o,
  output logic sda_o
);
  logic pull = 1'b0;
  initial scl_o = 1'b1;
  // Wired-and with a pull-up, so a released line reads high
  assign sda_o = ~(pull | dev_pull_i);
  task automatic half();
    repeat (10) @(negedge core_clk_i);
  endtask
  task automatic start();
    pull = 1'b0;
    half();
    scl_o = 1'b1;
    half();
    pull = 1'b1;
    half();
    scl_o = 1'b0;
  endtask
  task automatic stop();
    pull = 1'b1;
    half();
    scl_o = 1'b1;
    half();
    pull = 1'b0;
    half();
  endtask
  task automatic bit_io(input logic b, output logic r);
    pull = ~b;
    half();
    scl_o = 1'b1;
    half();
    r = sda_o;
    scl_o = 1'b0;
  endtask
  task automatic byte_io(input logic [7:0] b, output logic [7:0] r, output logic ack);
    logic a;
    for (int i = 7; i >= 0; i--)
      bit_io(b[i], r[i]);
    bit_io(1'b1, a);
    ack = ~a;
  endtask
  task automatic access(input logic rd, input logic [7:0] code, input logic [7:0] wdata,
    output logic [7:0] rdata, output logic ok);
    logic [7:0] r;
    logic a0, a1, a2, n;
    start();
    byte_io({DEV_ADDR, 1'b0}, r, a0);
    byte_io(code, r, a1);
    if (rd)
      start();
    byte_io(rd ? {DEV_ADDR, 1'b1} : wdata, r, a2);
    if (rd)
      byte_io(8'hff, rdata, n);
    stop();
    ok = a0 & a1 & a2;
  endtask
endmodule
`default_nettype wire

// ### tb/test_pse_detect_resistance_readout.sv
// Self-checking bench for the detection resistance readout
`timescale 1ns/1ps
`default_nettype none
module test_pse_detect_resistance_readout;
  localparam int COOL = 20;
  localparam logic [7:0] VALS [4] = '{8'h81, 8'h7e, 8'h32, 8'hff};
  logic core_clk_i = 1'b0;
  logic nrst_i = 1'b0;
  logic scl, sda, sda_o, sda_oe;
  logic [3:0] meas_done = 4'h0, busy = 4'h0, off = 4'h0;
  logic [3:0] f_st = 4'h0, f_oc = 4'h0, f_cl = 4'h0;
  logic [31:0] code = 32'h0;
  logic [3:0] det, cls, cooling;
  int error_cnt = 0;
  int checks = 0;
  int starts [4] = '{0, 0, 0, 0};
  int cls_starts = 0;
  always #12.5 core_clk_i = ~core_clk_i;
  always @(posedge core_clk_i)
    for (int p = 0; p < 4; p++)
      starts[p] <= starts[p] + int'(det[p]);
  always @(posedge core_clk_i)
    cls_starts <= cls_starts + int'(cls[1]);
  pse_detect_resistance_readout #(.COOL_DOWN_CYCLES(COOL)) pse_detect_resistance_readout_inst (
    .core_clk_i(core_clk_i), .nrst_i(nrst_i), .scl_i(scl), .sda_i(sda), .sda_o(sda_o),
    .sda_oe_o(sda_oe), .meas_done_i(meas_done), .meas_code_i(code), .cycle_busy_i(busy),
    .detect_start_o(det), .class_start_o(cls), .port_off_i(off), .startup_fault_i(f_st),
    .overcurrent_cut_fault_i(f_oc), .current_limit_fault_i(f_cl), .cooling_o(cooling));
  serial_host serial_host_inst (.core_clk_i(core_clk_i), .dev_pull_i(sda_oe), .scl_o(scl),
    .sda_o(sda));
  task automatic stop_test();
    $display("Checks %0d errors %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rd_check(input logic [7:0] c, input logic [7:0] exp);
    logic [7:0] d;
    logic ok;
    serial_host_inst.access(1'b1, c, 8'h00, d, ok);
    cmp({7'h00, ok}, 8'h01);
    cmp(d, exp);
  endtask
  task automatic wr(input logic [7:0] c, input logic [7:0] v);
    logic [7:0] d;
    logic ok;
    serial_host_inst.access(1'b0, c, v, d, ok);
    cmp({7'h00, ok}, 8'h01);
  endtask
  task automatic meas(input int p, input logic [7:0] v);
    @(negedge core_clk_i);
    code[8*p+:8] = v;
    meas_done[p] = 1'b1;
    @(negedge core_clk_i);
    meas_done[p] = 1'b0;
  endtask
  // Bounded wait; a missing start ends the run
  task automatic wait_start(input int p);
    int s;
    s = starts[p];
    for (int n = 0; n < 200; n++)
    begin
      @(negedge core_clk_i);
      if (starts[p] != s)
        return;
    end
    error_cnt++;
    stop_test();
  endtask
  task automatic sc_reset();
    wr(8'h44, 8'ha5);
    for (int c = 8'h44; c < 8'h49; c++)
      rd_check(8'(c), 8'h00);
  endtask
  task automatic sc_results();
    for (int p = 0; p < 4; p++)
      meas(p, VALS[p]);
    for (int p = 0; p < 4; p++)
      rd_check(8'h44 + 8'(p), VALS[p]);
    meas(0, 8'h3c);
    rd_check(8'h44, 8'h3c);
  endtask
  task automatic sc_restart();
    int s;
    int c0;
    c0 = cls_starts;
    wr(8'h60, 8'h01);
    wait_start(0);
    @(negedge core_clk_i);
    off[0] = 1'b1;
    @(negedge core_clk_i);
    off[0] = 1'b0;
    repeat (3) @(negedge core_clk_i);
    s = starts[0];
    rd_check(8'h60, 8'h00);
    cmp(8'(starts[0] - s), 8'h00);
    rd_check(8'h44, 8'h3c);
    wr(8'h60, 8'h01);
    wait_start(0);
    wr(8'h60, 8'h00);
    cmp({7'h00, cls_starts != c0}, 8'h00);
  endtask
  task automatic sc_fault();
    int s;
    int c0;
    wr(8'h60, 8'h22);
    c0 = cls_starts;
    for (int k = 0; k < 3; k++)
    begin
      wait_start(1);
      @(negedge core_clk_i);
      f_st[1] = (k == 0);
      f_oc[1] = (k == 1);
      f_cl[1] = (k == 2);
      @(negedge core_clk_i);
      {f_st, f_oc, f_cl} = 12'h000;
      cmp({7'h00, cooling[1]}, 8'h01);
      repeat (2) @(negedge core_clk_i);
      s = starts[1];
      repeat (COOL - 4) @(negedge core_clk_i);
      cmp(8'(starts[1] - s), 8'h00);
    end
    wait_start(1);
    cmp({7'h00, cls_starts != c0}, 8'h01);
    rd_check(8'h60, 8'h22);
    rd_check(8'h61, 8'h00);
  endtask
  initial
  begin
    repeat (3) @(negedge core_clk_i);
    nrst_i = 1'b1;
    sc_reset();
    sc_results();
    sc_restart();
    sc_fault();
    stop_test();
  end
endmodule
bind pse_detect_resistance_readout readout_checker #(.PORTS(PORTS), .COOL_DOWN_CYCLES(COOL_DOWN_CYCLES))
  readout_checker_inst (.*);
`default_nettype wire
